//--- sgoc_pkg.sv
/*
  Shared constants for the switchgear object control block: register
  offsets, field positions, reset values, encodings and timing counts.
  Assumes a 200 MHz clock and a 1 ms internal timing tick.
*/
package sgoc_pkg;

  // Clock and tick
  localparam int CLK_MHZ         = 200;
  localparam int TICK_US         = 1000;
  localparam int TICK_CYCLES     = CLK_MHZ * TICK_US;
  localparam int TICK_W          = 18;

  // Timing settings in ms, each a count of ticks
  localparam int SET_W           = 20;
  localparam int TRAVERSE_MS     = 200;
  localparam int CLOSE_PULSE_MS  = 200;
  localparam int OPEN_PULSE_MS   = 200;
  localparam int TERM_MS         = 10000;
  localparam int FINAL_MS        = 200;
  localparam int STEP_MS         = 20;

  // Register offsets
  localparam logic [3:0] REG_CONFIG   = 4'h0;
  localparam logic [3:0] REG_TRAVERSE = 4'h1;
  localparam logic [3:0] REG_CLOSE_PL = 4'h2;
  localparam logic [3:0] REG_OPEN_PL  = 4'h3;
  localparam logic [3:0] REG_TERM     = 4'h4;
  localparam logic [3:0] REG_FINAL    = 4'h5;
  localparam logic [3:0] REG_STATUS   = 4'h6;
  localparam logic [3:0] REG_EVENTS   = 4'h7;

  // Config field positions
  localparam int CFG_TYPE_LSB    = 0;
  localparam int CFG_SYNC_BIT    = 2;
  localparam int CFG_READY_LSB   = 3;
  localparam int CFG_ACCESS_LSB  = 5;
  localparam int CFG_W           = 7;

  // Object type
  localparam logic [1:0] TYPE_WD_BREAKER = 2'h0;
  localparam logic [1:0] TYPE_BREAKER    = 2'h1;
  localparam logic [1:0] TYPE_DISC_CTRL  = 2'h2;
  localparam logic [1:0] TYPE_EARTH      = 2'h3;

  // Readiness use
  localparam logic [1:0] RDY_HIGH   = 2'h0;
  localparam logic [1:0] RDY_LOW    = 2'h1;
  localparam logic [1:0] RDY_UNUSED = 2'h2;

  // Access levels
  localparam logic [1:0] ACC_USER   = 2'h0;
  localparam logic [1:0] ACC_OPER   = 2'h1;
  localparam logic [1:0] ACC_CONFIG = 2'h2;
  localparam logic [1:0] ACC_SUPER  = 2'h3;

  // Position state encoding
  localparam logic [1:0] POS_INTER  = 2'h0;
  localparam logic [1:0] POS_OPEN   = 2'h1;
  localparam logic [1:0] POS_CLOSED = 2'h2;
  localparam logic [1:0] POS_BAD    = 2'h3;
  localparam logic [2:0] WD_UNUSED  = 3'h4;

  // Reset value of config: fixed breaker, no sync, ready unused, configurator
  localparam logic [CFG_W-1:0] CFG_RESET = 7'h51;

  // Sticky event bits
  localparam int EV_OPEN_FAIL   = 0;
  localparam int EV_CLOSE_FAIL  = 1;
  localparam int EV_CLOSE_BLOCK = 2;
  localparam int EV_FINAL       = 3;
  localparam int EV_W           = 4;

endpackage

//--- sgoc_tick.sv
/*
  Free running tick generator: one-cycle pulse every TICK_CYCLES clocks.
  Assumes one clock domain with asynchronous active-low reset.
*/
`timescale 1ns/100ps
module sgoc_tick #(
  parameter int PERIOD = sgoc_pkg::TICK_CYCLES
) (
  input  wire logic clk,
  input  wire logic rstn,
  output logic      tick
);

  typedef struct packed {
    logic [sgoc_pkg::TICK_W-1:0] cnt;
    logic                        tick;
  } sgoc_tick_t;

  sgoc_tick_t st_ff;
  sgoc_tick_t nxt_st;

  //////////////////////////////////////////////////////////////////////
  // Count down and pulse at wrap
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == '0) begin
      nxt_st.cnt  = sgoc_pkg::TICK_W'(PERIOD - 1);
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule

//--- sgoc_pos.sv
/*
  Position decoder for one pair of status inputs with a traverse window.
  Reports intermediate, open, closed or bad; a mismatch pair is only
  reported once traverse ticks have been counted since the last clean pair.
  Assumes tick is a one-cycle pulse of the internal timing tick.
*/
`timescale 1ns/100ps
module sgoc_pos #(
  parameter int W = sgoc_pkg::SET_W
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         tick,
  input  wire logic         open_in,
  input  wire logic         closed_in,
  input  wire logic [W-1:0] traverse,
  output logic [1:0]        state
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic [1:0]   state;
  } sgoc_pos_t;

  sgoc_pos_t st_ff;
  sgoc_pos_t nxt_st;

  //////////////////////////////////////////////////////////////////////
  // Clean positions show at once, ambiguous ones after the window
  always_comb begin
    nxt_st = st_ff;
    if (open_in ^ closed_in) begin
      nxt_st.cnt   = '0;
      nxt_st.state = open_in ? sgoc_pkg::POS_OPEN : sgoc_pkg::POS_CLOSED;
    end else begin
      if (tick && st_ff.cnt < traverse) begin
        nxt_st.cnt = st_ff.cnt + 1'b1;
      end
      if (st_ff.cnt >= traverse) begin
        nxt_st.state = open_in ? sgoc_pkg::POS_BAD : sgoc_pkg::POS_INTER;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign state = st_ff.state;

endmodule

//--- sgoc_top.sv
/*
  Switchgear object control and monitoring.
  Decodes object and cart position, gates and times open/close pulses to
  the output relays, supervises termination and drives final trip.
  Assumes synchronous inputs, a 200 MHz clock and a plain register port
  with read data one cycle after the read strobe.
*/
`timescale 1ns/100ps
module sgoc_top #(
  parameter int SET_W = sgoc_pkg::SET_W,
  parameter int TICK  = sgoc_pkg::TICK_CYCLES
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  // Register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [31:0]           reg_rdata,
  // Apparatus status
  input  wire logic             open_status_in,
  input  wire logic             closed_status_in,
  input  wire logic             cart_inserted_input,
  input  wire logic             cart_removed_input,
  input  wire logic             object_ready_in,
  input  wire logic             sync_permit_in,
  // Command sources
  input  wire logic             local_close_in,
  input  wire logic             local_open_in,
  input  wire logic             remote_close_in,
  input  wire logic             remote_open_in,
  input  wire logic             app_close_in,
  input  wire logic             app_open_in,
  input  wire logic             panel_close_in,
  input  wire logic             panel_open_in,
  input  wire logic [1:0]       panel_access_in,
  input  wire logic             open_block_in,
  input  wire logic             close_block_in,
  input  wire logic             final_trip_req_in,
  input  wire logic             reclose_expected_in,
  // Relay and status outputs
  output logic                  open_relay_out,
  output logic                  close_relay_out,
  output logic                  final_trip_out,
  output logic                  cmd_fail_out,
  output logic [1:0]            breaker_state_out
);

  typedef enum logic [2:0] {
    SGOC_IDLE  = 3'b001,
    SGOC_OPEN  = 3'b010,
    SGOC_CLOSE = 3'b100
  } sgoc_st_t;

  typedef struct packed {
    sgoc_st_t                        fsm;
    logic [SET_W-1:0]                pulse_cnt;
    logic [SET_W-1:0]                term_cnt;
    logic                            open_on;
    logic                            close_on;
    logic [SET_W-1:0]                final_cnt;
    logic                            final_on;
    logic                            fail;
    logic [sgoc_pkg::EV_W-1:0]       events;
    logic [sgoc_pkg::CFG_W-1:0]      cfg;
    logic [SET_W-1:0]                traverse;
    logic [SET_W-1:0]                close_pl;
    logic [SET_W-1:0]                open_pl;
    logic [SET_W-1:0]                term;
    logic [SET_W-1:0]                final_pl;
    logic [31:0]                     rdata;
  } sgoc_top_t;

  sgoc_top_t st_ff;
  sgoc_top_t nxt_st;

  logic       tick;
  logic [1:0] brk_state;
  logic [1:0] cart_state;

  //////////////////////////////////////////////////////////////////////
  // Helpers

  // Whether the object type may be commanded
  function automatic logic sgoc_ctrl_ok(input logic [1:0] typ);
    sgoc_ctrl_ok = (typ != sgoc_pkg::TYPE_EARTH);
  endfunction

  // Whether the object type applies ready and sync gating
  function automatic logic sgoc_gated(input logic [1:0] typ);
    sgoc_gated = (typ == sgoc_pkg::TYPE_WD_BREAKER) || (typ == sgoc_pkg::TYPE_BREAKER);
  endfunction

  logic [1:0] obj_type;
  logic [1:0] rdy_use;
  logic [1:0] acc_min;
  logic       sync_use;
  logic       ready_ok;
  logic       sync_ok;
  logic       panel_ok;
  logic       open_req;
  logic       close_req;

  //////////////////////////////////////////////////////////////////////
  // Submodules
  sgoc_tick #(
    .PERIOD (TICK)
  ) u_tick (
    .clk  (clk),
    .rstn (rstn),
    .tick (tick)
  );

  sgoc_pos #(
    .W (SET_W)
  ) u_brk (
    .clk       (clk),
    .rstn      (rstn),
    .tick      (tick),
    .open_in   (open_status_in),
    .closed_in (closed_status_in),
    .traverse  (st_ff.traverse),
    .state     (brk_state)
  );

  // Cart reuses the decoder: removed maps to open, inserted to closed
  sgoc_pos #(
    .W (SET_W)
  ) u_cart (
    .clk       (clk),
    .rstn      (rstn),
    .tick      (tick),
    .open_in   (cart_removed_input),
    .closed_in (cart_inserted_input),
    .traverse  (st_ff.traverse),
    .state     (cart_state)
  );

  //////////////////////////////////////////////////////////////////////
  // Request gating
  always_comb begin
    obj_type  = st_ff.cfg[sgoc_pkg::CFG_TYPE_LSB +: 2];
    rdy_use   = st_ff.cfg[sgoc_pkg::CFG_READY_LSB +: 2];
    acc_min   = st_ff.cfg[sgoc_pkg::CFG_ACCESS_LSB +: 2];
    sync_use  = st_ff.cfg[sgoc_pkg::CFG_SYNC_BIT];
    // Ready level chosen by configuration
    ready_ok  = (rdy_use == sgoc_pkg::RDY_UNUSED) ||
                (rdy_use == sgoc_pkg::RDY_HIGH && object_ready_in) ||
                (rdy_use == sgoc_pkg::RDY_LOW && !object_ready_in);
    sync_ok   = !sync_use || sync_permit_in;
    if (!sgoc_gated(obj_type)) begin
      ready_ok = 1'b1;
      sync_ok  = 1'b1;
    end
    panel_ok  = (panel_access_in >= acc_min);
    open_req  = local_open_in || remote_open_in || app_open_in ||
                (panel_open_in && panel_ok);
    close_req = local_close_in || remote_close_in || app_close_in ||
                (panel_close_in && panel_ok);
    open_req  = open_req && !open_block_in && sgoc_ctrl_ok(obj_type);
    close_req = close_req && !close_block_in && sgoc_ctrl_ok(obj_type);
  end

  //////////////////////////////////////////////////////////////////////
  // Next state: command sequencer, final trip, registers
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.rdata = '0;

    // Command sequencer
    unique case (st_ff.fsm)
      SGOC_IDLE: begin
        // Open takes priority over close when both arrive together
        if (open_req && brk_state != sgoc_pkg::POS_OPEN) begin
          nxt_st.fsm       = SGOC_OPEN;
          nxt_st.open_on   = 1'b1;
          nxt_st.pulse_cnt = '0;
          nxt_st.term_cnt  = '0;
        end else if (close_req && brk_state != sgoc_pkg::POS_CLOSED) begin
          if (ready_ok && sync_ok) begin
            nxt_st.fsm       = SGOC_CLOSE;
            nxt_st.close_on  = 1'b1;
            nxt_st.pulse_cnt = '0;
            nxt_st.term_cnt  = '0;
          end else begin
            nxt_st.events[sgoc_pkg::EV_CLOSE_BLOCK] = 1'b1;
          end
        end
      end
      SGOC_OPEN, SGOC_CLOSE: begin
        // New requests are not looked at here
        if (tick) begin
          nxt_st.pulse_cnt = st_ff.pulse_cnt + 1'b1;
          nxt_st.term_cnt  = st_ff.term_cnt + 1'b1;
        end
        if ((st_ff.fsm == SGOC_OPEN && brk_state == sgoc_pkg::POS_OPEN) ||
            (st_ff.fsm == SGOC_CLOSE && brk_state == sgoc_pkg::POS_CLOSED)) begin
          nxt_st.open_on  = 1'b0;
          nxt_st.close_on = 1'b0;
          nxt_st.fsm      = SGOC_IDLE;
        end else begin
          if (st_ff.fsm == SGOC_OPEN && st_ff.pulse_cnt >= st_ff.open_pl) begin
            nxt_st.open_on = 1'b0;
          end
          if (st_ff.fsm == SGOC_CLOSE && st_ff.pulse_cnt >= st_ff.close_pl) begin
            nxt_st.close_on = 1'b0;
          end
          if (st_ff.term_cnt >= st_ff.term) begin
            nxt_st.open_on  = 1'b0;
            nxt_st.close_on = 1'b0;
            nxt_st.fail     = 1'b1;
            nxt_st.fsm      = SGOC_IDLE;
            if (st_ff.fsm == SGOC_OPEN) begin
              nxt_st.events[sgoc_pkg::EV_OPEN_FAIL] = 1'b1;
            end else begin
              nxt_st.events[sgoc_pkg::EV_CLOSE_FAIL] = 1'b1;
            end
          end
        end
      end
    endcase

    // Final trip pulse
    if (final_trip_req_in && !reclose_expected_in) begin
      nxt_st.final_on  = 1'b1;
      nxt_st.final_cnt = '0;
      nxt_st.events[sgoc_pkg::EV_FINAL] = 1'b1;
    end else if (st_ff.final_on && st_ff.final_pl != '0) begin
      if (tick) begin
        nxt_st.final_cnt = st_ff.final_cnt + 1'b1;
      end
      if (st_ff.final_cnt >= st_ff.final_pl) begin
        nxt_st.final_on = 1'b0;
      end
    end

    // Register writes; write-one clears bits already set, even if hardware sets them again
    if (reg_wr) begin
      unique case (reg_addr)
        sgoc_pkg::REG_CONFIG:   nxt_st.cfg      = reg_wdata[sgoc_pkg::CFG_W-1:0];
        sgoc_pkg::REG_TRAVERSE: nxt_st.traverse = reg_wdata[SET_W-1:0];
        sgoc_pkg::REG_CLOSE_PL: nxt_st.close_pl = reg_wdata[SET_W-1:0];
        sgoc_pkg::REG_OPEN_PL:  nxt_st.open_pl  = reg_wdata[SET_W-1:0];
        sgoc_pkg::REG_TERM:     nxt_st.term     = reg_wdata[SET_W-1:0];
        sgoc_pkg::REG_FINAL:    nxt_st.final_pl = reg_wdata[SET_W-1:0];
        sgoc_pkg::REG_EVENTS: begin
          // Only bits already set clear, even when set again this cycle; a new set survives
          nxt_st.events = nxt_st.events & ~(reg_wdata[sgoc_pkg::EV_W-1:0] & st_ff.events);
          nxt_st.fail   = nxt_st.fail && !st_ff.fail;
        end
        default: ;
      endcase
    end

    // Register reads, data in following cycle
    if (reg_rd) begin
      unique case (reg_addr)
        sgoc_pkg::REG_CONFIG:   nxt_st.rdata = 32'(st_ff.cfg);
        sgoc_pkg::REG_TRAVERSE: nxt_st.rdata = 32'(st_ff.traverse);
        sgoc_pkg::REG_CLOSE_PL: nxt_st.rdata = 32'(st_ff.close_pl);
        sgoc_pkg::REG_OPEN_PL:  nxt_st.rdata = 32'(st_ff.open_pl);
        sgoc_pkg::REG_TERM:     nxt_st.rdata = 32'(st_ff.term);
        sgoc_pkg::REG_FINAL:    nxt_st.rdata = 32'(st_ff.final_pl);
        sgoc_pkg::REG_STATUS:   nxt_st.rdata = {22'h00_0000, st_ff.fsm,
                                  (obj_type == sgoc_pkg::TYPE_WD_BREAKER) ?
                                  {1'b0, cart_state} : sgoc_pkg::WD_UNUSED,
                                  ready_ok, sync_ok, brk_state};
        sgoc_pkg::REG_EVENTS:   nxt_st.rdata = 32'(st_ff.events);
        default:                nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff          <= '0;
      st_ff.fsm      <= SGOC_IDLE;
      st_ff.cfg      <= sgoc_pkg::CFG_RESET;
      st_ff.traverse <= SET_W'(sgoc_pkg::TRAVERSE_MS);
      st_ff.close_pl <= SET_W'(sgoc_pkg::CLOSE_PULSE_MS);
      st_ff.open_pl  <= SET_W'(sgoc_pkg::OPEN_PULSE_MS);
      st_ff.term     <= SET_W'(sgoc_pkg::TERM_MS);
      st_ff.final_pl <= SET_W'(sgoc_pkg::FINAL_MS);
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from flip-flops
  assign open_relay_out    = st_ff.open_on;
  assign close_relay_out   = st_ff.close_on;
  assign final_trip_out    = st_ff.final_on;
  assign cmd_fail_out      = st_ff.fail;
  assign breaker_state_out = brk_state;
  assign reg_rdata         = st_ff.rdata;

  //////////////////////////////////////////////////////////////////////
  // Checks
  relay_excl_a: assert property (@(posedge clk) disable iff (!rstn)
    !(open_relay_out && close_relay_out)) else $error("both relays driven");
  earth_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
    (obj_type == sgoc_pkg::TYPE_EARTH && st_ff.fsm == SGOC_IDLE) |=> !open_relay_out && !close_relay_out)
    else $error("earth switch commanded");
  close_len_a: assert property (@(posedge clk) disable iff (!rstn)
    (close_relay_out && st_ff.pulse_cnt > st_ff.close_pl) |-> 1'b0)
    else $error("close pulse too long");
  open_len_a: assert property (@(posedge clk) disable iff (!rstn)
    (open_relay_out && st_ff.pulse_cnt > st_ff.open_pl) |-> 1'b0)
    else $error("open pulse too long");
  reach_end_a: assert property (@(posedge clk) disable iff (!rstn)
    (open_relay_out && brk_state == sgoc_pkg::POS_OPEN) |=> !open_relay_out)
    else $error("open pulse kept after reaching open");
  term_fail_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_ff.fsm != SGOC_IDLE && st_ff.term_cnt >= st_ff.term &&
     !(open_relay_out && brk_state == sgoc_pkg::POS_OPEN) &&
     !(close_relay_out && brk_state == sgoc_pkg::POS_CLOSED) &&
     st_ff.fsm == SGOC_OPEN && brk_state != sgoc_pkg::POS_OPEN) |=> cmd_fail_out)
    else $error("timeout without failure");
  sync_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_ff.fsm == SGOC_IDLE && !open_req && close_req && !sync_ok) |=> !close_relay_out)
    else $error("close without sync");
  final_cont_a: assert property (@(posedge clk) disable iff (!rstn)
    (final_trip_out && st_ff.final_pl == '0 && !reg_wr) |=> final_trip_out)
    else $error("continuous final trip dropped");
  busy_ign_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_ff.fsm == SGOC_OPEN && brk_state != sgoc_pkg::POS_OPEN &&
     st_ff.term_cnt < st_ff.term) |=> st_ff.fsm == SGOC_OPEN)
    else $error("busy command abandoned");

endmodule

//--- sgoc_brk_model.sv
/*
  Breaker apparatus model: moves its contacts after relay pulses.
  Assumes one clock; stuck freezes the contacts in place.
*/
`timescale 1ns/100ps
module sgoc_brk_model #(
  parameter int MOVE = 15
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic open_cmd,
  input  wire logic close_cmd,
  input  wire logic stuck,
  output logic      open_st,
  output logic      closed_st
);
  int cnt;
  // Leaves one end one cycle after the command is seen, reaches the other after MOVE cycles
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      open_st   <= 1'b1;
      closed_st <= 1'b0;
      cnt       <= 0;
    end else if (!stuck && ((open_cmd && !open_st) || (close_cmd && !closed_st))) begin
      cnt <= cnt + 1;
      if (cnt == 1) begin
        open_st   <= 1'b0;
        closed_st <= 1'b0;
      end
      if (cnt == MOVE) begin
        open_st   <= open_cmd;
        closed_st <= close_cmd;
        cnt       <= 0;
      end
    end
  end
endmodule

//--- switchgear_object_control_tb.sv
/*
  Testbench for the switchgear object control block.
  Assumes a 10-cycle timing tick and the breaker model on the far side.
*/
`timescale 1ns/100ps
module switchgear_object_control_tb;
  localparam int TK = 10;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic [31:0] reg_rdata;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  cmd = 8'h00;
  logic [1:0]  acc = 2'h1;
  logic        ready = 1'b0;
  logic        sync = 1'b0;
  logic        recl = 1'b0;
  logic        stuck = 1'b0;
  logic        cart_in = 1'b1;
  logic        cart_out = 1'b0;
  logic        blk = 1'b0;
  logic        opn_st, cls_st, o_rel, c_rel, f_out, fail;
  logic [1:0]  bstate;
  wire  [2:0]  rel = {f_out, c_rel, o_rel};
  int          mismatches = 0;
  int          total_checks = 0;
  int          n;
  // Clock
  always #2.5 clk = ~clk;
  sgoc_top #(.TICK(TK)) sgoc_top_i (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .open_status_in(opn_st), .closed_status_in(cls_st), .cart_inserted_input(cart_in),
    .cart_removed_input(cart_out), .object_ready_in(ready), .sync_permit_in(sync),
    .local_close_in(cmd[0]), .local_open_in(cmd[1]), .remote_close_in(cmd[2]),
    .remote_open_in(cmd[3]), .app_close_in(cmd[4]), .app_open_in(cmd[5]),
    .panel_close_in(cmd[6]), .panel_open_in(cmd[6]), .panel_access_in(acc),
    .open_block_in(blk), .close_block_in(blk), .final_trip_req_in(cmd[7]),
    .reclose_expected_in(recl), .open_relay_out(o_rel), .close_relay_out(c_rel),
    .final_trip_out(f_out), .cmd_fail_out(fail), .breaker_state_out(bstate));
  sgoc_brk_model sgoc_brk_model_i (.clk(clk), .rstn(rstn), .open_cmd(o_rel),
    .close_cmd(c_rel), .stuck(stuck), .open_st(opn_st), .closed_st(cls_st));
  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_len(input string nm, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("mismatch %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata);
  endtask
  // One-cycle request on one command line
  task automatic pulse(input int i);
    @(posedge clk);
    cmd[i] <= 1'b1;
    @(posedge clk);
    cmd <= 8'h00;
    #1;
  endtask
  // Cycles an output stays high, capped at 800
  task automatic run_len(input int k, output int c);
    c = 0;
    repeat (20) if (rel[k] !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    while (rel[k] === 1'b1 && c < 800) begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(4'h0, 32'h0000_0051);
    rd(4'h1, 32'h0000_00c8);
    rd(4'h8, 32'h0000_0000);
    wr(4'h1, 32'h0000_0003);
    wr(4'h2, 32'h0000_0005);
    wr(4'h3, 32'h0000_0005);
    wr(4'h4, 32'h0000_0014);
    wr(4'h5, 32'h0000_0004);
    #1 chk("state", {30'h0, sgoc_pkg::POS_OPEN}, {30'h0, bstate});
    rd(4'h6, 32'h0000_00cd);
    wr(4'h0, 32'h0000_0050);
    rd(4'h6, 32'h0000_00ad);
    // Cart leaves both ends, then shows both
    @(posedge clk);
    cart_in <= 1'b0;
    repeat (5 * TK) @(posedge clk);
    rd(4'h6, 32'h0000_008d);
    @(posedge clk);
    cart_in <= 1'b1;
    cart_out <= 1'b1;
    rd(4'h6, 32'h0000_00bd);
    pulse(0);
    run_len(1, n);
    chk_len("close", 15, 20, n);
    repeat (2) @(posedge clk);
    #1 chk("state", {30'h0, sgoc_pkg::POS_CLOSED}, {30'h0, bstate});
    pulse(6);
    run_len(0, n);
    chk_len("panel", 0, 0, n);
    stuck <= 1'b1;
    pulse(3);
    run_len(0, n);
    chk_len("open", 4 * TK, 6 * TK + 4, n);
    pulse(1);
    run_len(0, n);
    chk_len("busy", 0, 0, n);
    repeat (16 * TK) @(posedge clk);
    #1 chk("fail", 32'h0000_0001, {31'h0, fail});
    rd(4'h7, 32'h0000_0001);
    wr(4'h7, 32'h0000_000f);
    stuck <= 1'b0;
    #1 chk("fail", 32'h0000_0000, {31'h0, fail});
    wr(4'h0, 32'h0000_0053);
    pulse(1);
    run_len(0, n);
    chk_len("earth", 0, 0, n);
    wr(4'h0, 32'h0000_0051);
    pulse(5);
    run_len(0, n);
    chk_len("app open", 15, 20, n);
    wr(4'h0, 32'h0000_0055);
    pulse(4);
    run_len(1, n);
    chk_len("nosync", 0, 0, n);
    rd(4'h7, 32'h0000_0004);
    @(posedge clk);
    sync <= 1'b1;
    wr(4'h0, 32'h0000_0045);
    pulse(2);
    run_len(1, n);
    chk_len("noready", 0, 0, n);
    @(posedge clk);
    ready <= 1'b1;
    pulse(2);
    run_len(1, n);
    chk_len("ready", 15, 20, n);
    // Block raised well ahead of the request
    @(posedge clk);
    blk <= 1'b1;
    repeat (5 * TK) @(posedge clk);
    pulse(1);
    run_len(0, n);
    chk_len("blocked", 0, 0, n);
    @(posedge clk);
    blk <= 1'b0;
    acc <= 2'h2;
    pulse(6);
    run_len(0, n);
    chk_len("panel ok", 15, 20, n);
    // Stuck breaker: close pulse capped, then timeout
    stuck <= 1'b1;
    pulse(0);
    run_len(1, n);
    chk_len("close max", 4 * TK, 6 * TK + 4, n);
    repeat (16 * TK) @(posedge clk);
    rd(4'h7, 32'h0000_0006);
    stuck <= 1'b0;
    @(posedge clk);
    recl <= 1'b1;
    pulse(7);
    run_len(2, n);
    chk_len("reclose", 0, 0, n);
    @(posedge clk);
    recl <= 1'b0;
    pulse(7);
    run_len(2, n);
    chk_len("final", 3 * TK, 5 * TK + 4, n);
    wr(4'h5, 32'h0000_0000);
    pulse(7);
    run_len(2, n);
    chk_len("steady", 800, 800, n);
    rstn <= 1'b0;
    #1 chk("reset", 32'h0000_0000, {29'h0, f_out, bstate});
    tally_and_finish();
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule
